// File: design/xtd_capture.sv
`timescale 1ns/1ps
module xtd_capture import xtd_pkg::*; (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [15:0]  ch_pin,
  input  wire logic         master_clk_pin,
  input  wire logic         strobe_j,
  input  wire logic         strobe_k,
  input  wire logic         strobe_l,
  input  wire logic         strobe_m,
  output logic      [7:0]   thresh_lo,
  output logic      [7:0]   thresh_hi,
  output logic      [1:0]   ana_mode,
  output logic      [15:0]  main_data,
  output logic              main_valid,
  output logic      [15:0]  ext_data,
  output logic              ext_valid
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ch_s1;
    logic [15:0] ch_s2;
    logic        emu_s1;
    logic        emu_s2;
    logic        emu_d;
    logic [7:0]  latch;
    logic        seen;
    xtd_cfg_s    stg;
    xtd_cfg_s    act;
    logic [15:0] raw;
    logic [15:0] main_data;
    logic        main_valid;
    logic [15:0] ext_data;
    logic        ext_valid;
    logic [7:0]  cnt;
    logic [31:0] prdata;
  } xtd_core_s;

  xtd_core_s  r;
  xtd_core_s  next_r;
  xtd_slave_e eff_slave;
  logic       master;
  logic       wr;
  logic       commit;
  logic [7:0] lo_byte;
  logic [15:0] polar;

  xtd_cfg_if cfg ();

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  xtd_strobe u_strobe (
    .pclk     (pclk),
    .presetn  (presetn),
    .strobe_j (strobe_j),
    .strobe_k (strobe_k),
    .strobe_l (strobe_l),
    .strobe_m (strobe_m),
    .cfg      (cfg.strb)
  );

  xtd_label_map u_label (
    .cfg (cfg.lbl)
  );

  assign cfg.edge_sel = r.act.edges;
  assign cfg.labels   = r.act.labels;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic is_label(input logic [7:0] a);
    return (a[7:5] == XTD_OFS_LABEL[7:5]) && (a[1:0] == 2'b00);
  endfunction : is_label

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == XTD_OFS_CTRL) || (a == XTD_OFS_THRESH) || (a == XTD_OFS_COMMIT) ||
           (a == XTD_OFS_STATUS) || is_label(a);
  endfunction : addr_ok

  function automatic logic [31:0] lbl_word(input xtd_lbl_s l);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[XTD_LBL_DEF_POS]                      = l.def;
    w[XTD_LBL_NEG_POS]                      = l.neg;
    w[XTD_LBL_START_POS +: 4]               = l.start;
    w[XTD_LBL_WIDTH_POS +: 5]               = l.width;
    return w;
  endfunction : lbl_word

  // ------------------------------------------------------------
  // mode decode and slave interval sampling
  // ------------------------------------------------------------
  // slave clocks only exist in state mode; emulation always samples direct
  assign eff_slave = (r.act.mode == XTD_MODE_STATE) ? r.act.slave : XTD_SLV_OFF;
  assign master    = r.emu_s2 & ~r.emu_d;
  assign wr        = psel & penable & pwrite;
  assign commit    = wr & (paddr == XTD_OFS_COMMIT);
  // latched byte only if a slave edge came in this interval
  assign lo_byte   = r.seen ? r.latch : r.ch_s2[7:0];

  always_comb begin
    next_r            = r;
    next_r.ch_s1      = ch_pin;
    next_r.ch_s2      = r.ch_s1;
    next_r.emu_s1     = master_clk_pin;
    next_r.emu_s2     = r.emu_s1;
    next_r.emu_d      = r.emu_s2;
    next_r.main_valid = 1'b0;
    next_r.ext_valid  = 1'b0;
    polar             = 16'h0000;

    // a master sample opens a fresh interval
    if (master) begin
      next_r.seen = 1'b0;
    end
    // later slave edges are dropped; a slave edge in the master cycle counts for the next interval
    if (cfg.slave_pulse && (!r.seen || master)) begin
      next_r.latch = r.ch_s2[7:0];
      next_r.seen  = 1'b1;
    end

    if (master) begin
      case (eff_slave)
        XTD_SLV_MIXED: begin
          next_r.raw = {r.ch_s2[15:8], lo_byte};
        end
        XTD_SLV_DEMUX: begin
          next_r.raw = {r.ch_s2[7:0], lo_byte};
        end
        default: begin
          next_r.raw = r.ch_s2;
        end
      endcase
      polar      = next_r.raw ^ cfg.pol_mask;
      next_r.cnt = r.cnt + 8'h01;
      case (r.act.mode)
        XTD_MODE_EMU: begin
          next_r.main_data  = polar;
          next_r.main_valid = 1'b1;
        end
        XTD_MODE_STATE: begin
          next_r.ext_data  = polar;
          next_r.ext_valid = 1'b1;
        end
        default: begin
          next_r.cnt = r.cnt; // timing path lives elsewhere
        end
      endcase
    end

    // register writes land in the staged copy
    if (wr) begin
      if (paddr == XTD_OFS_CTRL) begin
        next_r.stg.emu_ctrl = pwdata[XTD_CTRL_EMU_POS];
        next_r.stg.mode     = xtd_mode_e'(pwdata[XTD_CTRL_MODE_POS +: 2]);
        next_r.stg.slave    = xtd_slave_e'(pwdata[XTD_CTRL_SLAVE_POS +: 2]);
        next_r.stg.edges    = pwdata[XTD_CTRL_EDGE_POS +: 8];
      end
      if (paddr == XTD_OFS_THRESH) begin
        next_r.stg.thr_lo = xtd_thr_pick(xtd_thr_e'(pwdata[XTD_THR_LOSEL_POS +: 2]),
                                         pwdata[XTD_THR_LO_POS +: 8]);
        next_r.stg.thr_hi = xtd_thr_pick(xtd_thr_e'(pwdata[XTD_THR_HISEL_POS +: 2]),
                                         pwdata[XTD_THR_HI_POS +: 8]);
      end
      if (is_label(paddr)) begin
        next_r.stg.labels[paddr[4:2]].def   = pwdata[XTD_LBL_DEF_POS];
        next_r.stg.labels[paddr[4:2]].neg   = pwdata[XTD_LBL_NEG_POS];
        next_r.stg.labels[paddr[4:2]].start = pwdata[XTD_LBL_START_POS +: 4];
        next_r.stg.labels[paddr[4:2]].width = pwdata[XTD_LBL_WIDTH_POS +: 5];
      end
    end

    // whole table copied, so old labels do not survive a commit
    if (commit && r.stg.emu_ctrl) begin
      next_r.act = r.stg;
    end

    // read data staged in the setup phase, valid in the access phase
    if (psel && !penable && !pwrite) begin
      next_r.prdata = 32'h0000_0000;
      if (paddr == XTD_OFS_CTRL) begin
        next_r.prdata[XTD_CTRL_EMU_POS]        = r.stg.emu_ctrl;
        next_r.prdata[XTD_CTRL_MODE_POS +: 2]  = r.stg.mode;
        next_r.prdata[XTD_CTRL_SLAVE_POS +: 2] = r.stg.slave;
        next_r.prdata[XTD_CTRL_EDGE_POS +: 8]  = r.stg.edges;
      end
      if (paddr == XTD_OFS_THRESH) begin
        next_r.prdata[XTD_THR_LO_POS +: 8] = r.stg.thr_lo;
        next_r.prdata[XTD_THR_HI_POS +: 8] = r.stg.thr_hi;
      end
      if (paddr == XTD_OFS_STATUS) begin
        next_r.prdata[XTD_ST_MODE_POS +: 2]  = r.act.mode;
        next_r.prdata[XTD_ST_SLAVE_POS +: 2] = r.act.slave;
        next_r.prdata[XTD_ST_SEEN_POS]       = r.seen;
        next_r.prdata[XTD_ST_EMU_POS]        = r.stg.emu_ctrl;
        next_r.prdata[XTD_ST_CNT_POS +: 8]   = r.cnt;
      end
      if (is_label(paddr)) begin
        next_r.prdata = lbl_word(r.stg.labels[paddr[4:2]]);
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r     <= '0;
      r.stg <= XTD_CFG_RST;
      r.act <= XTD_CFG_RST;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata     = r.prdata;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~addr_ok(paddr);
  assign thresh_lo  = r.act.thr_lo;
  assign thresh_hi  = r.act.thr_hi;
  assign ana_mode   = r.act.mode;
  assign main_data  = r.main_data;
  assign main_valid = r.main_valid;
  assign ext_data   = r.ext_data;
  assign ext_valid  = r.ext_valid;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_emu_main;
    master && r.act.mode == XTD_MODE_EMU |=> main_valid && !ext_valid;
  endproperty
  a_emu_main: assert property (p_emu_main) else $error("emulation sample missing");

  property p_withhold;
    main_valid |-> $past(r.act.mode) == XTD_MODE_EMU;
  endproperty
  a_withhold: assert property (p_withhold) else $error("main path fed outside emulation");

  property p_off_direct;
    master && eff_slave == XTD_SLV_OFF |=> r.raw == $past(r.ch_s2);
  endproperty
  a_off_direct: assert property (p_off_direct) else $error("direct sample wrong");

  property p_mixed_hi;
    master && eff_slave == XTD_SLV_MIXED && r.seen |=> r.raw == {$past(r.ch_s2[15:8]), $past(r.latch)};
  endproperty
  a_mixed_hi: assert property (p_mixed_hi) else $error("mixed sample wrong");

  property p_mixed_none;
    master && eff_slave == XTD_SLV_MIXED && !r.seen |=> r.raw[7:0] == $past(r.ch_s2[7:0]);
  endproperty
  a_mixed_none: assert property (p_mixed_none) else $error("mixed live byte wrong");

  property p_first_only;
    r.seen && !master && cfg.slave_pulse |=> r.latch == $past(r.latch);
  endproperty
  a_first_only: assert property (p_first_only) else $error("later slave edge overwrote latch");

  property p_demux;
    master && eff_slave == XTD_SLV_DEMUX && r.seen |=> r.raw[15:8] == $past(r.ch_s2[7:0])
                                                     && r.raw[7:0] == $past(r.latch);
  endproperty
  a_demux: assert property (p_demux) else $error("demux sample wrong");

  property p_demux_same;
    master && eff_slave == XTD_SLV_DEMUX && !r.seen |=> r.raw[7:0] == r.raw[15:8];
  endproperty
  a_demux_same: assert property (p_demux_same) else $error("demux bytes differ");

  property p_commit;
    commit && r.stg.emu_ctrl |=> r.act == $past(r.stg);
  endproperty
  a_commit: assert property (p_commit) else $error("commit not applied");

  property p_no_ctrl;
    !(commit && r.stg.emu_ctrl) |=> $stable(r.act);
  endproperty
  a_no_ctrl: assert property (p_no_ctrl) else $error("active setting changed without commit");

  property p_clear;
    master && !cfg.slave_pulse |=> !r.seen;
  endproperty
  a_clear: assert property (p_clear) else $error("slave flag not cleared");

  // mode 3 behaves like timing, so only the two live modes are checked
  property p_polar;
    master && (r.act.mode == XTD_MODE_EMU || r.act.mode == XTD_MODE_STATE)
      |=> (main_valid ? main_data : ext_data) == (r.raw ^ $past(cfg.pol_mask));
  endproperty
  a_polar: assert property (p_polar) else $error("polarity not applied");

  // routing per mode and interval bookkeeping
  property p_state_ext;
    master && r.act.mode == XTD_MODE_STATE |=> ext_valid && !main_valid;
  endproperty
  a_state_ext: assert property (p_state_ext) else $error("state sample on wrong path");

  property p_timing_quiet;
    master && r.act.mode == XTD_MODE_TIMING |=> !main_valid && !ext_valid;
  endproperty
  a_timing_quiet: assert property (p_timing_quiet) else $error("timing mode produced a sample");

  property p_emu_direct;
    master && r.act.mode == XTD_MODE_EMU |=> main_data == ($past(r.ch_s2) ^ $past(cfg.pol_mask));
  endproperty
  a_emu_direct: assert property (p_emu_direct) else $error("emulation sample not direct");

  property p_first_latch;
    cfg.slave_pulse && (!r.seen || master) |=> r.latch == $past(r.ch_s2[7:0]);
  endproperty
  a_first_latch: assert property (p_first_latch) else $error("slave edge did not latch");

  // set must win over the master clear, or the edge is lost
  property p_seen_set;
    cfg.slave_pulse |=> r.seen;
  endproperty
  a_seen_set: assert property (p_seen_set) else $error("slave flag not set");

  c_mixed: cover property (master && eff_slave == XTD_SLV_MIXED && r.seen);
  c_demux: cover property (master && eff_slave == XTD_SLV_DEMUX && r.seen);
  c_twice: cover property (r.seen && cfg.slave_pulse && !master);
  c_commit: cover property (commit && r.stg.emu_ctrl);
  c_refuse: cover property (commit && !r.stg.emu_ctrl);

endmodule : xtd_capture

// File: design/xtd_label_map.sv
`timescale 1ns/1ps
module xtd_label_map import xtd_pkg::*; (
  xtd_cfg_if.lbl cfg
);

  // label bounds; malformed entries are simply ignored
  function automatic logic covers(input xtd_lbl_s l, input int bit_idx);
    int s;
    int w;
    s = int'(l.start);
    w = int'(l.width);
    return l.def && (w > 0) && (s + w <= XTD_NCH) && (bit_idx >= s) && (bit_idx < s + w);
  endfunction : covers

  // ------------------------------------------------------------
  // a channel reads inverted when a negative label covers it
  // ------------------------------------------------------------
  always_comb begin
    cfg.pol_mask = 16'h0000;
    for (int b = 0; b < XTD_NCH; b++) begin
      for (int i = 0; i < XTD_NLBL; i++) begin
        if (covers(cfg.labels[i], b) && cfg.labels[i].neg) begin
          cfg.pol_mask[b] = 1'b1;
        end
      end
    end
  end

endmodule : xtd_label_map

// File: design/xtd_strobe.sv
`timescale 1ns/1ps
module xtd_strobe import xtd_pkg::*; (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  strobe_j,
  input  wire logic  strobe_k,
  input  wire logic  strobe_l,
  input  wire logic  strobe_m,
  xtd_cfg_if.strb    cfg
);

  typedef struct packed {
    logic [XTD_NSTRB-1:0] s1;
    logic [XTD_NSTRB-1:0] s2;
    logic [XTD_NSTRB-1:0] d;
  } xtd_strb_s;

  xtd_strb_s r;
  xtd_strb_s next_r;
  logic      pulse;

  // ------------------------------------------------------------
  // synchronise strobes; j,k from probe, l,m from emulator
  // ------------------------------------------------------------
  always_comb begin
    next_r    = r;
    next_r.s1 = {strobe_m, strobe_l, strobe_k, strobe_j};
    next_r.s2 = r.s1;
    next_r.d  = r.s2;
    pulse     = 1'b0;
    // edges compared on s2 only, s1 stays a pure synchroniser stage
    for (int i = 0; i < XTD_NSTRB; i++) begin
      pulse = pulse | (cfg.edge_sel[2*i+XTD_EDGE_RISE_BIT] & r.s2[i] & ~r.d[i])
                    | (cfg.edge_sel[2*i+XTD_EDGE_FALL_BIT] & ~r.s2[i] & r.d[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cfg.slave_pulse = pulse;

endmodule : xtd_strobe

// File: inc/xtd_cfg_if.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// configuration and slave-clock carrier between core and helpers
// ------------------------------------------------------------
interface xtd_cfg_if import xtd_pkg::*; ();
  logic [7:0]  edge_sel;
  logic        slave_pulse;
  xtd_lbl_t    labels;
  logic [15:0] pol_mask;

  modport core (output edge_sel, output labels, input slave_pulse, input pol_mask);
  modport strb (input edge_sel, output slave_pulse);
  modport lbl  (input labels, output pol_mask);
endinterface : xtd_cfg_if

// File: inc/xtd_pkg.sv
package xtd_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int XTD_NCH   = 16;
  localparam int XTD_NLBL  = 8;
  localparam int XTD_NSTRB = 4;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] XTD_OFS_CTRL   = 8'h00;
  localparam logic [7:0] XTD_OFS_THRESH = 8'h04;
  localparam logic [7:0] XTD_OFS_COMMIT = 8'h08;
  localparam logic [7:0] XTD_OFS_STATUS = 8'h0c;
  localparam logic [7:0] XTD_OFS_LABEL  = 8'h20;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int XTD_CTRL_EMU_POS   = 0;
  localparam int XTD_CTRL_MODE_POS  = 1;
  localparam int XTD_CTRL_SLAVE_POS = 3;
  localparam int XTD_CTRL_EDGE_POS  = 5;
  localparam int XTD_THR_LO_POS     = 0;
  localparam int XTD_THR_LOSEL_POS  = 8;
  localparam int XTD_THR_HI_POS     = 16;
  localparam int XTD_THR_HISEL_POS  = 24;
  localparam int XTD_LBL_DEF_POS    = 0;
  localparam int XTD_LBL_NEG_POS    = 1;
  localparam int XTD_LBL_START_POS  = 2;
  localparam int XTD_LBL_WIDTH_POS  = 6;
  localparam int XTD_ST_MODE_POS    = 0;
  localparam int XTD_ST_SLAVE_POS   = 2;
  localparam int XTD_ST_SEEN_POS    = 4;
  localparam int XTD_ST_EMU_POS     = 5;
  localparam int XTD_ST_CNT_POS     = 8;
  localparam int XTD_EDGE_RISE_BIT  = 0;
  localparam int XTD_EDGE_FALL_BIT  = 1;

  // ------------------------------------------------------------
  // threshold coding, millivolts
  // ------------------------------------------------------------
  localparam int XTD_THR_MIN_MV  = -6400;
  localparam int XTD_THR_STEP_MV = 50;
  localparam int XTD_TTL_MV      = 1400;
  localparam int XTD_CMOS_MV     = 2500;
  localparam int XTD_ECL_MV      = -1300;

  function automatic logic [7:0] xtd_mv_to_code(input int mv);
    int c;
    c = (mv - XTD_THR_MIN_MV) / XTD_THR_STEP_MV;
    return c[7:0];
  endfunction : xtd_mv_to_code

  localparam logic [7:0] XTD_THR_TTL  = xtd_mv_to_code(XTD_TTL_MV);
  localparam logic [7:0] XTD_THR_CMOS = xtd_mv_to_code(XTD_CMOS_MV);
  localparam logic [7:0] XTD_THR_ECL  = xtd_mv_to_code(XTD_ECL_MV);

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {XTD_MODE_EMU, XTD_MODE_STATE, XTD_MODE_TIMING} xtd_mode_e;
  typedef enum logic [1:0] {XTD_SLV_OFF, XTD_SLV_MIXED, XTD_SLV_DEMUX} xtd_slave_e;
  typedef enum logic [1:0] {XTD_THR_RAW, XTD_THR_SEL_TTL, XTD_THR_SEL_CMOS, XTD_THR_SEL_ECL} xtd_thr_e;

  typedef struct packed {
    logic       def;
    logic       neg;
    logic [3:0] start;
    logic [4:0] width;
  } xtd_lbl_s;
  typedef xtd_lbl_s [XTD_NLBL-1:0] xtd_lbl_t;

  typedef struct packed {
    logic       emu_ctrl;
    xtd_mode_e  mode;
    xtd_slave_e slave;
    logic [7:0] edges;
    logic [7:0] thr_lo;
    logic [7:0] thr_hi;
    xtd_lbl_t   labels;
  } xtd_cfg_s;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam xtd_lbl_s XTD_LBL_ALL = '{def: 1'b1, neg: 1'b0, start: 4'h0, width: 5'h10};
  localparam xtd_lbl_t XTD_LBL_RST =
    xtd_lbl_t'({{((XTD_NLBL-1)*$bits(xtd_lbl_s)){1'b0}}, XTD_LBL_ALL});
  localparam xtd_cfg_s XTD_CFG_RST = '{emu_ctrl: 1'b1, mode: XTD_MODE_EMU, slave: XTD_SLV_OFF,
                                       edges: 8'h00, thr_lo: XTD_THR_TTL, thr_hi: XTD_THR_TTL,
                                       labels: XTD_LBL_RST};

  // a preset select overrides the raw code
  function automatic logic [7:0] xtd_thr_pick(input xtd_thr_e sel, input logic [7:0] raw);
    case (sel)
      XTD_THR_SEL_TTL:  return XTD_THR_TTL;
      XTD_THR_SEL_CMOS: return XTD_THR_CMOS;
      XTD_THR_SEL_ECL:  return XTD_THR_ECL;
      default:          return raw;
    endcase
  endfunction : xtd_thr_pick

endpackage : xtd_pkg

// File: tb/xtd_capture_tb.sv
`timescale 1ns/1ps
module xtd_capture_tb import xtd_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mclk;
  logic [7:0]  paddr, thresh_lo, thresh_hi, es, hi, a, b, c0, c1;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ch_pin, main_data, ext_data, seen, mask;
  logic [3:0]  strb;
  logic [1:0]  ana_mode;
  logic        main_valid, ext_valid, got_m, got_e, er;
  int          err_count, n_tests, ns, s, slv, st, w;
  int          pmv[4] = '{0, 1400, 2500, -1300};

  always #4 pclk = ~pclk;

  xtd_capture dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch_pin(ch_pin), .master_clk_pin(mclk), .strobe_j(strb[0]), .strobe_k(strb[1]),
    .strobe_l(strb[2]), .strobe_m(strb[3]), .thresh_lo(thresh_lo), .thresh_hi(thresh_hi),
    .ana_mode(ana_mode), .main_data(main_data), .main_valid(main_valid), .ext_data(ext_data),
    .ext_valid(ext_valid));
  xtd_target tgt_u (.pclk(pclk), .ch(ch_pin), .mclk(mclk), .strb(strb));

  // latch whichever path delivers a sample
  always @(posedge pclk) begin
    if (main_valid === 1'b1) begin
      got_m <= 1'b1;
      seen  <= main_data;
    end
    if (ext_valid === 1'b1) begin
      got_e <= 1'b1;
      seen  <= ext_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int t;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic cfg(input int md, input int sl, input logic [7:0] e);
    apb(1'b1, XTD_OFS_CTRL, 32'(1 + md * 2 + sl * 8 + e * 32));
    apb(1'b1, XTD_OFS_COMMIT, 32'h0000_0000);
  endtask : cfg

  function automatic logic [7:0] mvc(input int mv);
    return 8'((mv + 6400) / 50);
  endfunction : mvc

  // first selected edge of the toggled strobe decides the low byte
  function automatic logic [15:0] exp_smp(input int sl);
    logic [7:0] lo;
    lo = (ns > 0 && es[2 * s + int'(strb[s])]) ? a : b;
    case (sl)
      1:       return {hi, lo};
      2:       return {b, lo};
      default: return {hi, b};
    endcase
  endfunction : exp_smp

  task automatic run(input logic [15:0] exp, input logic em, input logic ex);
    got_m <= 1'b0;
    got_e <= 1'b0;
    tgt_u.frame(hi, a, b, ns, s);
    chk(got_m, em);
    chk(got_e, ex);
    if (em | ex) chk(seen, exp);
  endtask : run

  task automatic rnd;
    hi = 8'($urandom);
    a  = 8'($urandom);
    b  = 8'($urandom);
    ns = $urandom % 3;
    s  = $urandom % 4;
  endtask : rnd

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, got_m, got_e, seen} = '0;
    err_count = 0;
    n_tests   = 0;
    void'($urandom(72039));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(thresh_lo, mvc(1400));
    chk(thresh_hi, mvc(1400));
    chk(ana_mode, 2'd0);
    apb(1'b0, XTD_OFS_STATUS, 32'h0000_0000);
    chk(rd[5:0], 6'h20);
    apb(1'b0, XTD_OFS_LABEL, 32'h0000_0000);
    chk(rd, 32'h0000_0401);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // every preset and a raw code per group
    for (int p = 0; p < 4; p++) begin
      c0 = 8'($urandom);
      c1 = 8'($urandom);
      apb(1'b1, XTD_OFS_THRESH, {6'h00, 2'(p), c1, 6'h00, 2'(p), c0});
      apb(1'b1, XTD_OFS_COMMIT, 32'h0000_0000);
      chk(thresh_lo, p > 0 ? mvc(pmv[p]) : c0);
      chk(thresh_hi, p > 0 ? mvc(pmv[p]) : c1);
    end
    // commit without emulation control leaves everything alone
    apb(1'b1, XTD_OFS_CTRL, 32'h0000_0002);
    apb(1'b1, XTD_OFS_THRESH, 32'h0000_0011);
    apb(1'b1, XTD_OFS_COMMIT, 32'h0000_0000);
    chk(thresh_lo, mvc(-1300));
    chk(ana_mode, 2'd0);
    cfg(0, 0, 8'h00);
    chk(thresh_lo, 8'h11);
    apb(1'b0, XTD_OFS_THRESH, 32'h0000_0000);
    chk(rd, 32'h0000_0011);
    for (int i = 0; i < 4; i++) begin
      rnd();
      run({hi, b}, 1'b1, 1'b0);
    end
    // negative label over a random span, then dropped again
    st = $urandom % 16;
    w  = 1 + $urandom % (16 - st);
    mask = 16'(((1 << w) - 1) << st);
    apb(1'b1, XTD_OFS_LABEL + 8'h04, 32'(3 + st * 4 + w * 64));
    cfg(0, 0, 8'h00);
    rnd();
    run({hi, b} ^ mask, 1'b1, 1'b0);
    apb(1'b1, XTD_OFS_LABEL + 8'h04, 32'h0000_0000);
    cfg(0, 0, 8'h00);
    rnd();
    run({hi, b}, 1'b1, 1'b0);
    // state mode across slave modes, edges and strobe sources
    for (int i = 0; i < 30; i++) begin
      slv = $urandom % 3;
      es  = (i < 4) ? 8'hff : 8'($urandom);
      cfg(1, slv, es);
      rnd();
      run(exp_smp(slv), 1'b0, 1'b1);
    end
    cfg(2, 0, 8'h00);
    rnd();
    run(16'h0000, 1'b0, 1'b0);
    stop_test();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    stop_test();
  end
endmodule : xtd_capture_tb

// File: tb/xtd_target.sv
`timescale 1ns/1ps
// -------------------------------------------------------
// target side: probe channels, master clock, four strobes
// -------------------------------------------------------
module xtd_target (
  input  wire logic        pclk,
  output logic      [15:0] ch,
  output logic             mclk,
  output logic      [3:0]  strb
);
  // the master clock stands still low between frames
  initial begin
    ch   = 16'h0000;
    mclk = 1'b0;
    strb = 4'h0;
  end

  // one 128 ns master period; strobe s toggles ns times before the edge
  task automatic frame(input logic [7:0] hi, input logic [7:0] a, input logic [7:0] b,
                       input int ns, input int s);
    ch <= {hi, a};
    repeat (2) @(posedge pclk);
    if (ns > 0) strb[s] <= ~strb[s];
    repeat (2) @(posedge pclk);
    ch <= {hi, b};
    repeat (2) @(posedge pclk);
    if (ns > 1) strb[s] <= ~strb[s];
    repeat (2) @(posedge pclk);
    mclk <= 1'b1;
    repeat (4) @(posedge pclk);
    mclk <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : frame
endmodule : xtd_target
